// [rtl/ppfp_arr_if.sv]
/*
 Carrier between port control and the code array.
 Assumes the control side drives writes and the read address.
*/
`timescale 1ns/10ps
`include "ppfp_map.svh"
interface ppfp_arr_if;
	logic                      wrEn;
	logic                      eraseEn;
	logic [`PPFP_ADDR_W-1:0]   wrAddr;
	logic [7:0]                wrData;
	logic [`PPFP_ADDR_W-1:0]   rdAddr;
	logic [7:0]                rdData;
	modport mem (input wrEn, input eraseEn, input wrAddr, input wrData, input rdAddr, output rdData);
	modport ctl (output wrEn, output eraseEn, output wrAddr, output wrData, output rdAddr, input rdData);
endinterface

// [rtl/ppfp_array.sv]
/*
 Code array of flip-flops; programming only clears bits, erase sets all.
 Assumes write and erase are one-cycle pulses from the port control.
*/
`timescale 1ns/10ps
`include "ppfp_map.svh"
module ppfp_array (
	input wire logic ref_clk,
	input wire logic nrst,
	ppfp_arr_if.mem  arr
);
	logic [7:0] mem [`PPFP_DEPTH];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	genvar i;
	generate
		for (i = 0; i < `PPFP_DEPTH; i++) begin : g_cell
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst)
					mem[i] <= `PPFP_ERASED_BYTE;
				else if (arr.eraseEn)
					mem[i] <= `PPFP_ERASED_BYTE; // R11 R20
				else if (arr.wrEn && arr.wrAddr == `PPFP_ADDR_W'(i))
					mem[i] <= mem[i] & arr.wrData; // R12
			end
		end
	endgenerate

	assign arr.rdData = mem[arr.rdAddr];

	property p_and_write;
		logic [`PPFP_ADDR_W-1:0] a;
		logic [7:0] old;
		(arr.wrEn && !arr.eraseEn, a = arr.wrAddr, old = mem[arr.wrAddr] & arr.wrData) |=> mem[a] == old;
	endproperty
	a_and_write: assert property (p_and_write) else $error("program did not clear bits only"); // R12

	property p_erase_ff;
		logic [`PPFP_ADDR_W-1:0] a;
		(arr.eraseEn, a = arr.rdAddr) |=> mem[a] == `PPFP_ERASED_BYTE;
	endproperty
	a_erase_ff: assert property (p_erase_ff) else $error("erased cell not all ones"); // R20
endmodule

// [rtl/ppfp_map.svh]
/*
 Constants of the parallel flash program port: mode codes, signature
 locations, timing, register map. Assumes inclusion by bare name.
*/
// Overview of operation
// R1 - reset high, store strobe low: decode a,b,c,d
// R2 - programmer: twelve volts to write, high to read
// R3 - writes self-timed to completion after start
// R4 - programmer: address, data, mode, voltage, then strobe
// R5 - programmer: read back, rewrite on mismatch
// R6 - programmer: one pulse code, twenty-five lock/encryption
// R7 - verify returns code only with no locks
// R8 - programmer: power-cycle before verifying full array
// R9 - programmer: program every cell zero before erase
// R10 - programmer: erase strobe low at least 200 ms
// R11 - erase leaves array and locks all ones
// R12 - no rewrite of code until erase done
// R13 - signature at three fixed locations, c,d low
// R14 - third signature byte reads all ones
// R15 - programmer: address, data stable 48 periods around strobe
// R16 - programmer: strobe low 120 us, high 10 us
// R17 - programmer: voltage 10 us around the strobe
// R18 - drive data within 48 periods, release likewise
// R19 - locks one and two disable verify
// R20 - erased locations read all ones
// R21 - address and data pin mapping configurable; the code maps them fixed onto progAddr, progDataIn and progDataOut
`ifndef PPFP_MAP_SVH
`define PPFP_MAP_SVH

`define PPFP_ADDR_W        12
`define PPFP_DEPTH         4096
`define PPFP_MODE_PROG     4'h7
`define PPFP_MODE_VERIFY   4'h3
`define PPFP_MODE_LOCK1    4'hF
`define PPFP_MODE_LOCK2    4'hC
`define PPFP_MODE_LOCK3    4'hA
`define PPFP_MODE_SIG      4'h0
`define PPFP_MODE_ERASE    4'h8
`define PPFP_SIG_MAKER     12'h030
`define PPFP_SIG_PART      12'h031
`define PPFP_SIG_VOLT      12'h032
`define PPFP_VOLT_VAL      8'hFF
`define PPFP_ERASED_BYTE   8'hFF
`define PPFP_MAKER_VAL     8'h3C
`define PPFP_PART_VAL      8'hA7
`define PPFP_CLK_MHZ       200
`define PPFP_WRITE_TIME_US 100
`define PPFP_ERASE_TIME_US 1000
`define PPFP_CNT_W         24
`define PPFP_REG_CTRL      32'h0000_0000
`define PPFP_REG_STATUS    32'h0000_0004
`define PPFP_CTRL_EN_BIT   0
`define PPFP_CTRL_RST      1'h1
`define PPFP_STAT_REF_BIT  4
`define PPFP_RESP_OKAY     2'h0
`define PPFP_RESP_SLVERR   2'h2

`endif

// [rtl/ppfp_pkg.sv]
/*
 Types of the parallel flash program port.
 Assumes nothing of its surroundings.
*/
package ppfp_pkg;
	typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_VERIFY, OP_LOCK1, OP_LOCK2, OP_LOCK3, OP_SIG, OP_ERASE} ppfp_op_t;
	typedef enum logic {ST_IDLE, ST_BUSY} ppfp_state_t;
endpackage

// [rtl/ppfp_port.sv]
/*
 Parallel programming port of the embedded code flash, with an AXI4-Lite
 control and status slave. Assumes pins synchronous to ref_clk.
*/
`timescale 1ns/10ps
`include "ppfp_map.svh"
module ppfp_port #(
	parameter int WRITE_CYCLES = `PPFP_WRITE_TIME_US * `PPFP_CLK_MHZ,
	parameter int ERASE_CYCLES = `PPFP_ERASE_TIME_US * `PPFP_CLK_MHZ,
	parameter logic [7:0] MAKER_CODE = `PPFP_MAKER_VAL, // arbitrary value
	parameter logic [7:0] PART_CODE  = `PPFP_PART_VAL   // arbitrary value
) (
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic [31:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [31:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    progResetPin,
	input  wire logic                    programStoreStrobeN,
	input  wire logic                    writeStrobePinN,
	input  wire logic                    highVoltageAccessPin,
	input  wire logic                    modeSelectA,
	input  wire logic                    modeSelectB,
	input  wire logic                    modeSelectC,
	input  wire logic                    modeSelectD,
	input  wire logic [`PPFP_ADDR_W-1:0] progAddr,
	input  wire logic [7:0]              progDataIn,
	output logic [7:0]                   progDataOut,
	output logic                         progDataOe
);
	ppfp_arr_if arr ();

	ppfp_pkg::ppfp_state_t       state_ff;
	ppfp_pkg::ppfp_op_t          curOp_ff;
	ppfp_pkg::ppfp_op_t          pinOp;
	logic [`PPFP_CNT_W-1:0]      cnt_ff;
	logic [`PPFP_ADDR_W-1:0]     addrLat_ff;
	logic [7:0]                  dataLat_ff;
	logic                        strobePrev_ff;
	logic                        lockOne_ff;
	logic                        lockTwo_ff;
	logic                        lockThree_ff;
	logic                        portEn_ff;
	logic                        refused_ff;
	logic [7:0]                  dataOut_ff;
	logic                        dataOe_ff;
	logic [3:0]                  modeBits;
	logic                        modeActive;
	logic                        isWriteOp;
	logic                        anyLock;
	logic                        startReq;
	logic                        startOk;
	logic                        refuseEvt;
	logic                        commit;
	logic                        readCond;
	logic [7:0]                  sigByte;
	logic                        awHeld_ff;
	logic                        wHeld_ff;
	logic [31:0]                 awAddr_ff;
	logic [31:0]                 wData_ff;
	logic                        wStrb0_ff;
	logic                        doWrite;
	logic                        refClear;
	logic [31:0]                 statusWord;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	function automatic ppfp_pkg::ppfp_op_t decodeMode(input logic [3:0] m);
		case (m)
			`PPFP_MODE_PROG:   decodeMode = ppfp_pkg::OP_PROG;
			`PPFP_MODE_VERIFY: decodeMode = ppfp_pkg::OP_VERIFY;
			`PPFP_MODE_LOCK1:  decodeMode = ppfp_pkg::OP_LOCK1;
			`PPFP_MODE_LOCK2:  decodeMode = ppfp_pkg::OP_LOCK2;
			`PPFP_MODE_LOCK3:  decodeMode = ppfp_pkg::OP_LOCK3;
			`PPFP_MODE_SIG:    decodeMode = ppfp_pkg::OP_SIG;
			`PPFP_MODE_ERASE:  decodeMode = ppfp_pkg::OP_ERASE;
			default:           decodeMode = ppfp_pkg::OP_NONE;
		endcase
	endfunction

	// address and data pins map straight onto progAddr and progData
	assign modeBits   = {modeSelectA, modeSelectB, modeSelectC, modeSelectD}; // R21
	assign modeActive = progResetPin && !programStoreStrobeN; // R1
	assign pinOp      = modeActive ? decodeMode(modeBits) : ppfp_pkg::OP_NONE; // R1
	assign isWriteOp  = pinOp inside {ppfp_pkg::OP_PROG, ppfp_pkg::OP_LOCK1, ppfp_pkg::OP_LOCK2,
	                                  ppfp_pkg::OP_LOCK3, ppfp_pkg::OP_ERASE};
	assign anyLock    = lockOne_ff || lockTwo_ff || lockThree_ff;
	assign startReq   = strobePrev_ff && !writeStrobePinN && isWriteOp && highVoltageAccessPin && portEn_ff;
	// level one lock bars code programming until an erase
	assign startOk    = startReq && state_ff == ppfp_pkg::ST_IDLE
	                    && !(pinOp == ppfp_pkg::OP_PROG && lockOne_ff); // R12
	assign refuseEvt  = startReq && !startOk;
	assign commit     = state_ff == ppfp_pkg::ST_BUSY && cnt_ff == '0;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			strobePrev_ff <= 1'h1;
		else
			strobePrev_ff <= writeStrobePinN;
	end

	// self-timed write: one strobe edge starts it, counter ends it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff   <= ppfp_pkg::ST_IDLE;
			curOp_ff   <= ppfp_pkg::OP_NONE;
			cnt_ff     <= '0;
			addrLat_ff <= '0;
			dataLat_ff <= '0;
		end else if (startOk) begin
			state_ff   <= ppfp_pkg::ST_BUSY; // R3
			curOp_ff   <= pinOp;
			addrLat_ff <= progAddr;
			dataLat_ff <= progDataIn;
			cnt_ff     <= (pinOp == ppfp_pkg::OP_ERASE) ? `PPFP_CNT_W'(ERASE_CYCLES - 1)
			                                            : `PPFP_CNT_W'(WRITE_CYCLES - 1);
		end else if (state_ff == ppfp_pkg::ST_BUSY) begin
			if (commit)
				state_ff <= ppfp_pkg::ST_IDLE; // R3
			else
				cnt_ff <= cnt_ff - `PPFP_CNT_W'(1); // R3
		end
	end

	assign arr.wrEn    = commit && curOp_ff == ppfp_pkg::OP_PROG;
	assign arr.eraseEn = commit && curOp_ff == ppfp_pkg::OP_ERASE; // R11
	assign arr.wrAddr  = addrLat_ff;
	assign arr.wrData  = dataLat_ff;
	assign arr.rdAddr  = progAddr;

	ppfp_array u_array (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.arr     (arr)
	);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lockOne_ff   <= 1'h0;
			lockTwo_ff   <= 1'h0;
			lockThree_ff <= 1'h0;
		end else if (commit) begin
			case (curOp_ff)
				ppfp_pkg::OP_LOCK1: lockOne_ff   <= 1'h1;
				ppfp_pkg::OP_LOCK2: lockTwo_ff   <= 1'h1;
				ppfp_pkg::OP_LOCK3: lockThree_ff <= 1'h1;
				ppfp_pkg::OP_ERASE: begin
					lockOne_ff   <= 1'h0; // R11
					lockTwo_ff   <= 1'h0; // R11
					lockThree_ff <= 1'h0; // R11
				end
				default: ;
			endcase
		end
	end

	// read side: verify only while unlocked, signature regardless of locks; both only when idle
	assign readCond = modeActive && writeStrobePinN && state_ff == ppfp_pkg::ST_IDLE
	                  && ((pinOp == ppfp_pkg::OP_VERIFY && !anyLock) || pinOp == ppfp_pkg::OP_SIG); // R7 R19 R13

	always_comb begin
		case (progAddr)
			`PPFP_SIG_MAKER: sigByte = MAKER_CODE; // R13
			`PPFP_SIG_PART:  sigByte = PART_CODE;
			`PPFP_SIG_VOLT:  sigByte = `PPFP_VOLT_VAL; // R14
			default:         sigByte = `PPFP_ERASED_BYTE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dataOe_ff  <= 1'h0;
			dataOut_ff <= '0;
		end else begin
			dataOe_ff  <= readCond; // R18
			dataOut_ff <= (pinOp == ppfp_pkg::OP_SIG) ? sigByte : arr.rdData; // R20
		end
	end

	assign progDataOut = dataOut_ff;
	assign progDataOe  = dataOe_ff;

	// AXI4-Lite slave, one write and one read at a time
	assign s_axi_awready = !awHeld_ff;
	assign s_axi_wready  = !wHeld_ff;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite       = awHeld_ff && wHeld_ff && !s_axi_bvalid;
	assign refClear      = doWrite && awAddr_ff == `PPFP_REG_STATUS && wStrb0_ff && wData_ff[`PPFP_STAT_REF_BIT];
	assign statusWord    = {27'h0, refused_ff, lockThree_ff, lockTwo_ff, lockOne_ff, state_ff == ppfp_pkg::ST_BUSY};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			awHeld_ff <= 1'h0;
			awAddr_ff <= '0;
		end else if (s_axi_awvalid && !awHeld_ff) begin
			awHeld_ff <= 1'h1;
			awAddr_ff <= s_axi_awaddr;
		end else if (doWrite)
			awHeld_ff <= 1'h0;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wHeld_ff  <= 1'h0;
			wData_ff  <= '0;
			wStrb0_ff <= 1'h0;
		end else if (s_axi_wvalid && !wHeld_ff) begin
			wHeld_ff  <= 1'h1;
			wData_ff  <= s_axi_wdata;
			wStrb0_ff <= s_axi_wstrb[0];
		end else if (doWrite)
			wHeld_ff <= 1'h0;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp  <= `PPFP_RESP_OKAY;
			portEn_ff    <= `PPFP_CTRL_RST;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp  <= (awAddr_ff == `PPFP_REG_CTRL || awAddr_ff == `PPFP_REG_STATUS)
			                ? `PPFP_RESP_OKAY : `PPFP_RESP_SLVERR;
			if (awAddr_ff == `PPFP_REG_CTRL && wStrb0_ff)
				portEn_ff <= wData_ff[`PPFP_CTRL_EN_BIT];
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'h0;
	end

	// set wins over a same-cycle clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			refused_ff <= 1'h0;
		else if (refuseEvt)
			refused_ff <= 1'h1;
		else if (refClear)
			refused_ff <= 1'h0;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'h0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `PPFP_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'h1;
			s_axi_rresp  <= `PPFP_RESP_OKAY;
			if (s_axi_araddr == `PPFP_REG_CTRL)
				s_axi_rdata <= {31'h0, portEn_ff};
			else if (s_axi_araddr == `PPFP_REG_STATUS)
				s_axi_rdata <= statusWord;
			else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= `PPFP_RESP_SLVERR;
			end
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'h0;
	end

	property p_decode_prog;
		startOk && pinOp == ppfp_pkg::OP_PROG |=> state_ff == ppfp_pkg::ST_BUSY && curOp_ff == ppfp_pkg::OP_PROG;
	endproperty
	a_decode_prog: assert property (p_decode_prog) else $error("program code not started"); // R1

	property p_count_down;
		state_ff == ppfp_pkg::ST_BUSY && cnt_ff != '0
		|=> state_ff == ppfp_pkg::ST_BUSY && cnt_ff == $past(cnt_ff) - `PPFP_CNT_W'(1);
	endproperty
	a_count_down: assert property (p_count_down) else $error("write timer not counting"); // R3

	property p_commit_end;
		commit |-> (curOp_ff != ppfp_pkg::OP_PROG || arr.wrEn) ##1 state_ff == ppfp_pkg::ST_IDLE;
	endproperty
	a_commit_end: assert property (p_commit_end) else $error("write did not complete"); // R3

	property p_verify_lock;
		progDataOe && !$past(pinOp == ppfp_pkg::OP_SIG) |-> !$past(anyLock);
	endproperty
	a_verify_lock: assert property (p_verify_lock) else $error("code driven while locked"); // R7

	property p_lock12;
		lockOne_ff && lockTwo_ff && pinOp == ppfp_pkg::OP_VERIFY |=> !progDataOe;
	endproperty
	a_lock12: assert property (p_lock12) else $error("verify with locks one and two"); // R19

	property p_erase_locks;
		commit && curOp_ff == ppfp_pkg::OP_ERASE |=> !lockOne_ff && !lockTwo_ff && !lockThree_ff;
	endproperty
	a_erase_locks: assert property (p_erase_locks) else $error("locks survive erase"); // R11

	property p_lock1_refuse;
		startReq && pinOp == ppfp_pkg::OP_PROG && lockOne_ff |=> refused_ff && !arr.wrEn;
	endproperty
	a_lock1_refuse: assert property (p_lock1_refuse) else $error("locked program accepted"); // R12

	property p_sig_volt;
		readCond && pinOp == ppfp_pkg::OP_SIG && progAddr == `PPFP_SIG_VOLT
		|=> progDataOe && progDataOut == `PPFP_VOLT_VAL;
	endproperty
	a_sig_volt: assert property (p_sig_volt) else $error("voltage signature wrong"); // R14

	property p_release;
		!readCond ##1 !readCond |-> !progDataOe;
	endproperty
	a_release: assert property (p_release) else $error("data lines not released"); // R18
endmodule

// [verif/ppfp_port_bench.sv]
/*
 Self-checking bench of ppfp_port: AXI4-Lite master tasks and a programmer model.
 Assumes write/erase self-time shortened to 8 and 16 cycles.
*/
`timescale 1ns/10ps
`include "ppfp_map.svh"
module ppfp_port_bench;
	logic                    ref_clk, nrst;
	logic [31:0]             awaddr, wdata, araddr, rdata;
	logic                    awvalid, awready, wvalid, wready, bvalid, bready;
	logic                    arvalid, arready, rvalid, rready;
	logic [1:0]              bresp, rresp;
	logic                    rstPin, storeN, wrN, hv, oe, rdDone;
	logic [3:0]              modeSel, wstrb;
	logic [`PPFP_ADDR_W-1:0] addr;
	logic [7:0]              din, dout, d, d2;
	logic [9:0]              rdVal;
	logic [33:0]             busQ[$];
	logic [9:0]              flashQ[$];
	int                      fails, checks;

	ppfp_port #(.WRITE_CYCLES(8), .ERASE_CYCLES(16)) ppfp_port_i (.ref_clk(ref_clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .progResetPin(rstPin), .programStoreStrobeN(storeN), .writeStrobePinN(wrN),
		.highVoltageAccessPin(hv), .modeSelectA(modeSel[3]), .modeSelectB(modeSel[2]),
		.modeSelectC(modeSel[1]), .modeSelectD(modeSel[0]), .progAddr(addr), .progDataIn(din),
		.progDataOut(dout), .progDataOe(oe));

	ppfp_programmer ppfp_programmer_i (
		.ref_clk(ref_clk), .progResetPin(rstPin), .programStoreStrobeN(storeN), .writeStrobePinN(wrN),
		.highVoltageAccessPin(hv), .modeSel(modeSel), .progAddr(addr), .progDataIn(din),
		.progDataOut(dout), .progDataOe(oe), .rdDone(rdDone), .rdVal(rdVal));

	always #2.5 ref_clk = ~ref_clk;

	task automatic report_and_stop;
		fails += busQ.size() + flashQ.size();
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp_bus(input logic [33:0] got);
		logic [33:0] exp;
		exp = {34{1'bx}};
		if (busQ.size() > 0)
			exp = busQ.pop_front();
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: bus got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_flash(input logic [9:0] got);
		logic [9:0] exp;
		exp = {10{1'bx}};
		if (flashQ.size() > 0)
			exp = flashQ.pop_front();
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: flash got %h expected %h", $time, got, exp);
		end
	endtask

	always @(posedge ref_clk) begin
		if (rvalid && rready)
			cmp_bus({rresp, rdata});
		if (bvalid && bready)
			cmp_bus({bresp, 32'h0000_0000});
		if (rdDone)
			cmp_flash(rdVal);
	end

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r,
	                      input logic [3:0] s = 4'hF);
		bit pa, pw, pb, ta, tw, tb;
		@(posedge ref_clk);
		busQ.push_back({r, 32'h0000_0000});
		awaddr <= a;
		wdata <= v;
		wstrb <= {3'($urandom), s[0]};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1;
		pw = 1;
		pb = 1;
		while (pa || pw || pb) begin
			@(negedge ref_clk);
			ta = pa && awready;
			tw = pw && wready;
			tb = pb && bvalid;
			@(posedge ref_clk);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 0;
			end
			if (tb) begin
				bready <= 1'b0;
				pb = 0;
			end
		end
	endtask

	task automatic axi_rd(input logic [31:0] a, input logic [1:0] r, input logic [31:0] v);
		bit pa, pr, ta, tr;
		@(posedge ref_clk);
		busQ.push_back({r, v});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		pa = 1;
		pr = 1;
		while (pa || pr) begin
			@(negedge ref_clk);
			ta = pa && arready;
			tr = pr && rvalid;
			@(posedge ref_clk);
			if (ta) begin
				arvalid <= 1'b0;
				pa = 0;
			end
			if (tr) begin
				rready <= 1'b0;
				pr = 0;
			end
		end
	endtask

	task automatic flash_rd(input logic [3:0] m, input logic [11:0] a, input logic [8:0] v);
		flashQ.push_back({1'b0, v});
		ppfp_programmer_i.do_read(m, a);
	endtask

	initial begin
		#200000;
		fails++;
		report_and_stop;
	end

	initial begin
		void'($urandom(32'hBEF38B16));
		ref_clk = 1'b0;
		nrst = 1'b0;
		{awaddr, wdata, araddr} = {96{1'b0}};
		wstrb = 4'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		fails = 0;
		checks = 0;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		d = 8'($urandom);
		d2 = 8'($urandom);
		axi_rd(`PPFP_REG_CTRL, 2'h0, 32'h0000_0001);
		axi_rd(`PPFP_REG_STATUS, 2'h0, 32'h0000_0000);
		axi_wr(32'h0000_0010, 32'h0000_0000, 2'h2);
		axi_rd(32'h0000_0008, 2'h2, 32'h0000_0000);
		axi_wr(`PPFP_REG_CTRL, 32'h0000_0000, 2'h0, 4'hE);
		axi_rd(`PPFP_REG_CTRL, 2'h0, 32'h0000_0001);
		flash_rd(`PPFP_MODE_SIG, 12'h030, {1'b1, `PPFP_MAKER_VAL});
		flash_rd(`PPFP_MODE_SIG, 12'h031, {1'b1, `PPFP_PART_VAL});
		flash_rd(`PPFP_MODE_SIG, 12'h032, 9'h1FF);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, 9'h1FF);
		ppfp_programmer_i.do_write(`PPFP_MODE_PROG, 12'h123, d, 1);
		ppfp_programmer_i.set_power(1'b0);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, 9'h000);
		ppfp_programmer_i.set_power(1'b1);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, {1'b1, d});
		ppfp_programmer_i.do_write(`PPFP_MODE_PROG, 12'h123, d2, 1);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, {1'b1, d & d2});
		axi_wr(`PPFP_REG_CTRL, 32'h0000_0000, 2'h0);
		ppfp_programmer_i.do_write(`PPFP_MODE_PROG, 12'h123, 8'h00, 1);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, {1'b1, d & d2});
		axi_wr(`PPFP_REG_CTRL, 32'h0000_0001, 2'h0);
		ppfp_programmer_i.do_write(`PPFP_MODE_LOCK1, 12'h000, 8'h00, 25);
		axi_rd(`PPFP_REG_STATUS, 2'h0, 32'h0000_0002);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, 9'h000);
		ppfp_programmer_i.do_write(`PPFP_MODE_PROG, 12'h124, 8'h00, 1);
		axi_rd(`PPFP_REG_STATUS, 2'h0, 32'h0000_0012);
		axi_wr(`PPFP_REG_STATUS, 32'h0000_0010, 2'h0);
		axi_rd(`PPFP_REG_STATUS, 2'h0, 32'h0000_0002);
		ppfp_programmer_i.do_write(`PPFP_MODE_LOCK2, 12'h000, 8'h00, 25);
		ppfp_programmer_i.do_write(`PPFP_MODE_LOCK3, 12'h000, 8'h00, 25);
		axi_rd(`PPFP_REG_STATUS, 2'h0, 32'h0000_000E);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, 9'h000);
		ppfp_programmer_i.do_write(`PPFP_MODE_ERASE, 12'h000, 8'h00, 1);
		axi_rd(`PPFP_REG_STATUS, 2'h0, 32'h0000_0000);
		flash_rd(`PPFP_MODE_VERIFY, 12'h123, 9'h1FF);
		ppfp_programmer_i.do_write(`PPFP_MODE_PROG, 12'h124, d2, 1);
		flash_rd(`PPFP_MODE_VERIFY, 12'h124, {1'b1, d2});
		repeat (4) @(posedge ref_clk);
		report_and_stop;
	end
endmodule

// [verif/ppfp_programmer.sv]
/*
 Behavioural external programmer on the flash programming pins.
 Assumes a ppfp_port on the same ref_clk with shortened self-times;
 strobe low times stay above those self-times.
*/
`timescale 1ns/10ps
`include "ppfp_map.svh"
module ppfp_programmer #(
	parameter int VPP_CYC   = 4,
	parameter int LOW_CYC   = 12,
	parameter int GAP_CYC   = 4,
	parameter int ERASE_CYC = 24
) (
	input  wire logic                    ref_clk,
	output logic                         progResetPin,
	output logic                         programStoreStrobeN,
	output logic                         writeStrobePinN,
	output logic                         highVoltageAccessPin,
	output logic [3:0]                   modeSel,
	output logic [`PPFP_ADDR_W-1:0]      progAddr,
	output logic [7:0]                   progDataIn,
	input  wire logic [7:0]              progDataOut,
	input  wire logic                    progDataOe,
	output logic                         rdDone,
	output logic [9:0]                   rdVal
);
	localparam logic [3:0] IDLE_MODE = 4'h5;

	initial begin
		progResetPin = 1'b1;
		programStoreStrobeN = 1'b0;
		writeStrobePinN = 1'b1;
		highVoltageAccessPin = 1'b0;
		modeSel = IDLE_MODE;
		progAddr = 12'h000;
		progDataIn = 8'h00;
		rdDone = 1'b0;
		rdVal = 10'h000;
	end

	task automatic do_write(input logic [3:0] m, input logic [11:0] a, input logic [7:0] d, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			progAddr <= a;
			progDataIn <= d;
			modeSel <= m;
			repeat (48) @(posedge ref_clk);
			highVoltageAccessPin <= 1'b1;
			repeat (VPP_CYC) @(posedge ref_clk);
			writeStrobePinN <= 1'b0;
			repeat ((m == `PPFP_MODE_ERASE) ? ERASE_CYC : LOW_CYC) @(posedge ref_clk);
			writeStrobePinN <= 1'b1;
			repeat (VPP_CYC) @(posedge ref_clk);
			highVoltageAccessPin <= 1'b0;
			repeat (48) @(posedge ref_clk);
			progDataIn <= ~d;
			modeSel <= IDLE_MODE;
			repeat (GAP_CYC) @(posedge ref_clk);
		end
	endtask

	// supply off: reset pin low, store strobe released; on restores both
	task automatic set_power(input bit on);
		@(posedge ref_clk);
		progResetPin <= on;
		programStoreStrobeN <= !on;
		repeat (48) @(posedge ref_clk);
	endtask

	// reports {oe after leaving, oe, data}; data shown as 0 when not driven
	task automatic do_read(input logic [3:0] m, input logic [11:0] a);
		logic [8:0] v;
		@(posedge ref_clk);
		progAddr <= a;
		progDataIn <= ~progDataIn;
		modeSel <= m;
		repeat (48) @(posedge ref_clk);
		@(negedge ref_clk);
		v = {progDataOe, progDataOe ? progDataOut : 8'h00};
		@(posedge ref_clk);
		modeSel <= IDLE_MODE;
		repeat (48) @(posedge ref_clk);
		@(negedge ref_clk);
		rdVal <= {progDataOe, v};
		rdDone <= 1'b1;
		@(posedge ref_clk);
		rdDone <= 1'b0;
	endtask
endmodule
